// ===== rtl/osc_ctrl_pkg.sv
package osc_ctrl_pkg;

  // Oscillator mode as held in the configuration word
  typedef enum logic [2:0] {
    MODE_LOW_POWER_XTAL = 3'h0,
    MODE_MEDIUM_XTAL = 3'h1,
    MODE_HIGH_GAIN_XTAL = 3'h2,
    MODE_EXT_CLOCK = 3'h3,
    MODE_INT_OSC_IO = 3'h4,
    MODE_INT_OSC_CLOCK_OUT_FUNCTION = 3'h5,
    MODE_RC_IO = 3'h6,
    MODE_RC_CLOCK_OUT_FUNCTION = 3'h7
  } osc_mode_e;

  // Start-up sequence, Gray coded along arm -> wait -> count -> run
  typedef enum logic [1:0] {
    ST_ARM = 2'h0,
    ST_WAIT_PUT = 2'h1,
    ST_COUNT = 2'h3,
    ST_RUN = 2'h2
  } startup_state_e;

  // Amplifier gain codes
  localparam logic [1:0] GAIN_OFF = 2'h0;
  localparam logic [1:0] GAIN_LOW = 2'h1;
  localparam logic [1:0] GAIN_MEDIUM = 2'h2;
  localparam logic [1:0] GAIN_HIGH = 2'h3;

  // Pin function for the two oscillator pins
  typedef struct packed {
    logic in_is_gpio;
    logic out_is_gpio;
    logic out_is_clock_out_function;
  } pin_plan_s;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;

  // Control register fields
  localparam int CTRL_SCS_BIT = 0;
  localparam int CTRL_FREQ_LSB = 4;
  localparam logic [2:0] FREQ_RESET = 3'h6;
  localparam logic SCS_RESET = 1'b0;
  localparam logic [2:0] FREQ_LOW_OSC = 3'h0;
  localparam logic [2:0] FREQ_MAX = 3'h7;

  // Status register fields
  localparam int STAT_HF_STABLE_BIT = 0;
  localparam int STAT_STARTUP_DONE_BIT = 1;
  localparam int STAT_RUNNING_EXT_BIT = 2;
  localparam int STAT_SWITCHING_BIT = 3;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_TWO_SPEED_BIT = 7;

  // Timing counts, in oscillator edges
  localparam logic [10:0] STARTUP_EDGES = 11'h400;
  localparam logic [1:0] SWITCH_SETTLE_EDGES = 2'h2;

endpackage

// ===== rtl/oscillator_source_control.sv
// Summary of operation
// (R1) Crystal modes count 1024 input edges after reset, power-up timer expiry, or wake.
// (R2) Hold the program counter while the start-up count runs; with two-speed set, a crystal count runs with the core not held.
// (R3) External clock mode bypasses the start-up count entirely.
// (R4) External clock stopping just halts ticks; all state stays intact.
// (R5) When the external clock resumes, ticks continue from the held state.
// (R6) External clock mode: clock from input pin, output pin is general I/O.
// (R7) RC clock-out mode drives the RC frequency divided by 4 on output pin.
// (R8) RC I/O mode: RC clocks the input pin, output pin is general I/O.
// (R9) Internal clock-out mode: input pin is I/O, output pin drives internal clock/4.
// (R10) Internal I/O mode: both pins are I/O, no clock output.
// (R11) HF oscillator runs when frequency select nonzero and (clock select or two-speed).
// (R12) Status bit reads 1 while the HF oscillator is stable.
// (R13) HF oscillator feeds a postscaler; three-bit select chooses one of seven rates.
// (R14) Software clock select chooses external source or internal oscillator.
// (R15) Source change inserts a settle delay before the new source drives ticks.
// (R16) Crystal modes drive low, medium, high amplifier gain respectively.
// (R17) Select 111 is full rate, each lower code halves; 000 is low oscillator; reset 110.
// (R18) Clock select 1 routes internal oscillator, 0 the configured mode's source.
// (R19) Start-up counter clears on each qualifying event and holds done once complete.
`timescale 1ns/100ps
module oscillator_source_control
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Configuration word and system events
  input wire osc_ctrl_pkg::osc_mode_e CFG_MODE,
  input wire logic CFG_TWO_SPEED,
  input wire logic PUT_ENABLE,
  input wire logic PUT_EXPIRED,
  input wire logic WAKE,
  // Oscillator pins and analog oscillators
  input wire logic OSC_IN_PIN,
  input wire logic HF_OSC_CLK,
  input wire logic HF_OSC_READY,
  input wire logic LF_OSC_CLK,
  output logic OSC_OUT_O,
  output logic OSC_OUT_OE,
  output logic OSC_IN_GPIO,
  output logic OSC_OUT_GPIO,
  output logic [1:0] AMP_GAIN,
  output logic HF_OSC_EN,
  // Core clocking
  output logic SYS_TICK,
  output logic CPU_HOLD
);
  import osc_ctrl_pkg::*;

  function automatic logic is_crystal(input osc_mode_e m);
    is_crystal = (m == MODE_LOW_POWER_XTAL) || (m == MODE_MEDIUM_XTAL) || (m == MODE_HIGH_GAIN_XTAL);
  endfunction
  function automatic logic is_internal(input osc_mode_e m);
    is_internal = (m == MODE_INT_OSC_IO) || (m == MODE_INT_OSC_CLOCK_OUT_FUNCTION);
  endfunction
  function automatic pin_plan_s pin_plan(input osc_mode_e m);
    pin_plan = '0;
    case (m)
      MODE_EXT_CLOCK: pin_plan.out_is_gpio = 1'b1;
      MODE_RC_IO: pin_plan.out_is_gpio = 1'b1;
      MODE_RC_CLOCK_OUT_FUNCTION: pin_plan.out_is_clock_out_function = 1'b1;
      MODE_INT_OSC_CLOCK_OUT_FUNCTION: begin
        pin_plan.in_is_gpio = 1'b1;
        pin_plan.out_is_clock_out_function = 1'b1;
      end
      MODE_INT_OSC_IO: begin
        pin_plan.in_is_gpio = 1'b1;
        pin_plan.out_is_gpio = 1'b1;
      end
      default: pin_plan = '0;
    endcase
  endfunction
  // Postscaler hit: divide by 2^(7-sel) counted on HF edges
  function automatic logic post_hit(input logic [6:0] cnt, input logic [2:0] sel);
    logic [6:0] mask;
    mask = 7'h7f >> sel;
    post_hit = ((cnt & mask) == mask);
  endfunction
  // Synchronisers: stage 1 feeds only stage 2; stage 3 is for edge detection
  logic [2:0] osc_in_sync_reg;
  logic [2:0] hf_sync_reg;
  logic [2:0] lf_sync_reg;
  logic [1:0] hf_ready_sync_reg;
  logic osc_in_edge;
  logic hf_edge;
  logic lf_edge;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      osc_in_sync_reg <= '0;
      hf_sync_reg <= '0;
      lf_sync_reg <= '0;
      hf_ready_sync_reg <= '0;
    end else begin
      osc_in_sync_reg <= {osc_in_sync_reg[1:0], OSC_IN_PIN};
      hf_sync_reg <= {hf_sync_reg[1:0], HF_OSC_CLK};
      lf_sync_reg <= {lf_sync_reg[1:0], LF_OSC_CLK};
      hf_ready_sync_reg <= {hf_ready_sync_reg[0], HF_OSC_READY};
    end
  end
  assign osc_in_edge = osc_in_sync_reg[1] & ~osc_in_sync_reg[2];
  assign hf_edge = hf_sync_reg[1] & ~hf_sync_reg[2];
  assign lf_edge = lf_sync_reg[1] & ~lf_sync_reg[2];
  // Configuration captured after reset release
  osc_mode_e mode_reg;
  logic two_speed_reg;
  startup_state_e state_reg;
  startup_state_e state_next;
  logic [10:0] edge_cnt_reg;
  logic startup_done;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      mode_reg <= MODE_EXT_CLOCK;
      two_speed_reg <= 1'b0;
    end else if (state_reg == ST_ARM) begin
      mode_reg <= CFG_MODE;
      two_speed_reg <= CFG_TWO_SPEED;
    end
  end

  // Start-up sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_ARM: begin
        if (PUT_ENABLE)
          state_next = ST_WAIT_PUT;
        else if (is_crystal(CFG_MODE))
          state_next = ST_COUNT; // R1
        else
          state_next = ST_RUN; // R3
      end
      ST_WAIT_PUT: begin
        if (PUT_EXPIRED)
          state_next = is_crystal(mode_reg) ? ST_COUNT : ST_RUN; // R1 R3
      end
      ST_COUNT: begin
        if (osc_in_edge && edge_cnt_reg == STARTUP_EDGES - 11'h1)
          state_next = ST_RUN; // R1
      end
      ST_RUN: begin
        if (WAKE && is_crystal(mode_reg))
          state_next = ST_COUNT; // R1
      end
      default: state_next = ST_ARM;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST)
      state_reg <= ST_ARM;
    else
      state_reg <= state_next;
  end

  // Edge counter clears on every qualifying event and stops once done
  always_ff @(posedge REF_CLK) begin
    if (RST)
      edge_cnt_reg <= '0;
    else if (state_reg != ST_COUNT)
      edge_cnt_reg <= '0; // R19
    else if (osc_in_edge && edge_cnt_reg != STARTUP_EDGES - 11'h1)
      edge_cnt_reg <= edge_cnt_reg + 11'h1; // R1
  end

  assign startup_done = (state_reg == ST_RUN);

  // Software registers
  logic [2:0] freq_sel_reg;
  logic scs_reg;
  logic apb_write;
  logic apb_done;
  assign apb_done = PSEL & PENABLE & PREADY;
  assign apb_write = apb_done & PWRITE & (PADDR == OFS_CONTROL);
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      freq_sel_reg <= FREQ_RESET; // R17
      scs_reg <= SCS_RESET;
    end else if (apb_write) begin
      freq_sel_reg <= PWDATA[CTRL_FREQ_LSB +: 3]; // R13
      scs_reg <= PWDATA[CTRL_SCS_BIT]; // R14
    end
  end

  // Internal oscillator enable and stability
  logic hf_en_next;
  logic hf_stable_reg;
  assign hf_en_next = (freq_sel_reg != FREQ_LOW_OSC) && (scs_reg || two_speed_reg); // R11
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      HF_OSC_EN <= 1'b0;
      hf_stable_reg <= 1'b0;
    end else begin
      HF_OSC_EN <= hf_en_next; // R11
      hf_stable_reg <= HF_OSC_EN & hf_ready_sync_reg[1]; // R12
    end
  end

  // Postscaler on the HF oscillator, low oscillator taken directly for 000
  logic [6:0] post_cnt_reg;
  logic int_edge;
  always_ff @(posedge REF_CLK) begin
    if (RST)
      post_cnt_reg <= '0;
    else if (hf_edge)
      post_cnt_reg <= post_cnt_reg + 7'h1;
  end

  assign int_edge = (freq_sel_reg == FREQ_LOW_OSC) ? lf_edge :
                    (hf_edge && post_hit(post_cnt_reg, freq_sel_reg)); // R13 R17

  // Source choice; two-speed runs on the internal oscillator while a crystal starts
  logic use_int;
  logic use_int_reg;
  logic switching_reg;
  logic [1:0] settle_cnt_reg;
  logic new_edge;
  assign use_int = scs_reg || is_internal(mode_reg) ||
                   (two_speed_reg && is_crystal(mode_reg) && !startup_done); // R14 R18
  assign new_edge = use_int ? int_edge : osc_in_edge;

  // A change of source suppresses ticks until the new source shows settled edges
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      use_int_reg <= 1'b0;
      switching_reg <= 1'b0;
      settle_cnt_reg <= '0;
    end else if (use_int != use_int_reg) begin
      use_int_reg <= use_int;
      switching_reg <= 1'b1; // R15
      settle_cnt_reg <= '0;
    end else if (switching_reg && new_edge) begin
      if (settle_cnt_reg == SWITCH_SETTLE_EDGES - 2'h1)
        switching_reg <= 1'b0;
      settle_cnt_reg <= settle_cnt_reg + 2'h1;
    end
  end

  // Ticks follow source edges only; a stopped clock simply produces none
  logic tick_ok;
  assign tick_ok = !switching_reg && (use_int_reg == use_int) &&
                   (startup_done || use_int); // R2 R15
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      SYS_TICK <= 1'b0;
      CPU_HOLD <= 1'b1;
    end else begin
      SYS_TICK <= tick_ok && new_edge; // R4 R5 R14
      CPU_HOLD <= !startup_done && !(two_speed_reg && is_crystal(mode_reg)); // R2 R3
    end
  end

  // Clock output at a quarter of the system rate, held low while switching
  logic [1:0] div4_reg;
  pin_plan_s plan;
  assign plan = pin_plan(mode_reg);
  always_ff @(posedge REF_CLK) begin
    if (RST)
      div4_reg <= '0;
    else if (switching_reg)
      div4_reg <= '0;
    else if (tick_ok && new_edge)
      div4_reg <= div4_reg + 2'h1; // R7 R9
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      OSC_OUT_O <= 1'b0;
      OSC_OUT_OE <= 1'b0;
      OSC_IN_GPIO <= 1'b0;
      OSC_OUT_GPIO <= 1'b0;
    end else begin
      OSC_OUT_O <= plan.out_is_clock_out_function & div4_reg[1]; // R7 R9
      OSC_OUT_OE <= plan.out_is_clock_out_function; // R7 R9 R10
      OSC_IN_GPIO <= plan.in_is_gpio; // R9 R10
      OSC_OUT_GPIO <= plan.out_is_gpio; // R6 R8 R10
    end
  end

  // Amplifier gain from the crystal mode
  always_ff @(posedge REF_CLK) begin
    if (RST)
      AMP_GAIN <= GAIN_OFF;
    else begin
      case (mode_reg)
        MODE_LOW_POWER_XTAL: AMP_GAIN <= GAIN_LOW; // R16
        MODE_MEDIUM_XTAL: AMP_GAIN <= GAIN_MEDIUM; // R16
        MODE_HIGH_GAIN_XTAL: AMP_GAIN <= GAIN_HIGH; // R16
        default: AMP_GAIN <= GAIN_OFF;
      endcase
    end
  end

  // APB: one wait state, registered answer
  logic [31:0] rdata_next;
  logic addr_ok;
  assign addr_ok = (PADDR == OFS_CONTROL) || (PADDR == OFS_STATUS);
  always_comb begin
    rdata_next = '0;
    case (PADDR)
      OFS_CONTROL: begin
        rdata_next[CTRL_FREQ_LSB +: 3] = freq_sel_reg;
        rdata_next[CTRL_SCS_BIT] = scs_reg;
      end
      OFS_STATUS: begin
        rdata_next[STAT_HF_STABLE_BIT] = hf_stable_reg; // R12
        rdata_next[STAT_STARTUP_DONE_BIT] = startup_done;
        rdata_next[STAT_RUNNING_EXT_BIT] = !use_int_reg;
        rdata_next[STAT_SWITCHING_BIT] = switching_reg;
        rdata_next[STAT_MODE_LSB +: 3] = mode_reg;
        rdata_next[STAT_TWO_SPEED_BIT] = two_speed_reg;
      end
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~addr_ok;
      PRDATA <= (PSEL & PENABLE & ~PREADY & ~PWRITE) ? rdata_next : 32'h0;
    end
  end

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_hold_while_count: assert property ((state_reg == ST_COUNT && !two_speed_reg) |=> CPU_HOLD) // R2
    else $error("cpu not held during start-up count");
  a_count_completes: assert property ((state_reg == ST_COUNT && osc_in_edge && // R1
      edge_cnt_reg == STARTUP_EDGES - 11'h1) |=> state_reg == ST_RUN)
    else $error("start-up count did not finish at 1024 edges");
  a_ext_no_count: assert property ((mode_reg == MODE_EXT_CLOCK) |-> state_reg != ST_COUNT) // R3
    else $error("start-up count ran in external clock mode");
  a_no_edge_no_tick: assert property (!new_edge |=> !SYS_TICK) // R4
    else $error("tick without a source edge");
  a_ext_out_gpio: assert property ((mode_reg == MODE_EXT_CLOCK) [*2] |-> OSC_OUT_GPIO && !OSC_OUT_OE) // R6
    else $error("output pin not released in external clock mode");
  a_io_no_clock_out_function: assert property ((mode_reg == MODE_INT_OSC_IO) [*2] |-> !OSC_OUT_OE && OSC_IN_GPIO) // R10
    else $error("clock output driven in internal I/O mode");
  a_hf_enable: assert property ((HF_OSC_EN == $past(hf_en_next)) && // R11
      (!HF_OSC_EN || $past(freq_sel_reg) != FREQ_LOW_OSC))
    else $error("HF oscillator enable wrong");
  a_stable_flag: assert property (hf_stable_reg |-> $past(HF_OSC_EN)) // R12
    else $error("stable flag set with oscillator off");
  a_switch_quiet: assert property ($changed(use_int) |=> !SYS_TICK ##1 !SYS_TICK) // R15
    else $error("tick during source switch");
  a_gain_high: assert property ((mode_reg == MODE_HIGH_GAIN_XTAL) [*2] |-> AMP_GAIN == GAIN_HIGH) // R16
    else $error("wrong gain for high-gain crystal");
  a_counter_clears: assert property ((state_reg == ST_RUN && WAKE && is_crystal(mode_reg)) // R19
      |=> state_reg == ST_COUNT && edge_cnt_reg == 11'h0)
    else $error("start-up counter not cleared on wake");

endmodule

// ===== test/osc_source_model.sv
`timescale 1ns/100ps
module osc_source_model #(
  parameter int HALF_NS = 81
) (
  // Control
  input wire logic run,
  // Oscillator line
  output logic clk_out
);
  // A stopped source sits low, as a halted oscillator does, so no stale edge leaks out
  initial begin
    clk_out = 1'b0;
    forever begin
      #(HALF_NS);
      clk_out = run ? ~clk_out : 1'b0;
    end
  end
endmodule

// ===== test/tb_oscillator_source_control.sv
`timescale 1ns/100ps
module tb_oscillator_source_control;
  import osc_ctrl_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  osc_mode_e cfg_mode = MODE_EXT_CLOCK;
  logic put_enable = 1'b0, put_expired = 1'b0, wake = 1'b0, hf_ready = 1'b0, pin_run = 1'b0, two_speed = 1'b0;
  logic pready, pslverr, osc_in_pin, hf_clk, lf_clk, osc_out_o, osc_out_oe, osc_in_gpio, osc_out_gpio;
  logic hf_en, sys_tick, cpu_hold, err;
  logic [1:0] amp_gain;
  int n_errors = 0, total_checks = 0, cycles = 0, pin_edges = 0, ticks = 0;

  oscillator_source_control dut (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CFG_MODE(cfg_mode), .CFG_TWO_SPEED(two_speed), .PUT_ENABLE(put_enable), .PUT_EXPIRED(put_expired),
    .WAKE(wake), .OSC_IN_PIN(osc_in_pin), .HF_OSC_CLK(hf_clk), .HF_OSC_READY(hf_ready), .LF_OSC_CLK(lf_clk),
    .OSC_OUT_O(osc_out_o), .OSC_OUT_OE(osc_out_oe), .OSC_IN_GPIO(osc_in_gpio), .OSC_OUT_GPIO(osc_out_gpio),
    .AMP_GAIN(amp_gain), .HF_OSC_EN(hf_en), .SYS_TICK(sys_tick), .CPU_HOLD(cpu_hold));
  osc_source_model #(.HALF_NS(81)) pin_src (.run(pin_run), .clk_out(osc_in_pin));
  // The internal oscillator only runs while the block enables it
  osc_source_model #(.HALF_NS(161)) hf_src (.run(hf_en), .clk_out(hf_clk));
  osc_source_model #(.HALF_NS(1000)) lf_src (.run(1'b1), .clk_out(lf_clk));

  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge osc_in_pin) pin_edges++;
  // Updated late so that tasks sampling at the same edge always see the old count
  always @(posedge ref_clk) begin
    if (sys_tick === 1'b1) ticks <= ticks + 1;
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic check_range(input int got, input int lo, input int hi, input string msg);
    total_checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %0d exp %0d..%0d", $time, msg, got, lo, hi);
    end
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // No wait-state count is assumed; only the bench timeout ends a stalled access
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset(input osc_mode_e m, input logic put);
    @(posedge ref_clk);
    rst <= 1'b1;
    pin_run <= 1'b0;
    cfg_mode <= m;
    put_enable <= put;
    hf_ready <= 1'b0;
    wait_cycles(10);
    rst <= 1'b0;
    pin_run <= 1'b1;
    pin_edges = 0;
  endtask

  task automatic count_ticks(input int n, output int c);
    int t0;
    t0 = ticks;
    wait_cycles(n);
    c = ticks - t0;
  endtask

  task automatic hold_count();
    int i;
    for (i = 0; i < 8000 && pin_edges < 1000; i++) @(posedge ref_clk);
    check_val(cpu_hold, 1'b1, "core released early");
    for (i = 0; i < 2000 && cpu_hold !== 1'b0; i++) @(posedge ref_clk);
    check_range(pin_edges, 1024, 1027, "start-up edges");
  endtask

  task automatic wait_rise();
    int i;
    for (i = 0; i < 400 && osc_out_o !== 1'b0; i++) @(posedge ref_clk);
    for (i = 0; i < 400 && osc_out_o !== 1'b1; i++) @(posedge ref_clk);
  endtask

  task automatic t_regs();
    do_reset(MODE_EXT_CLOCK, 1'b0);
    apb(1'b0, OFS_CONTROL, 32'h0);
    check_val(rd, 32'h00000060, "control reset");
    apb(1'b1, 8'h08, 32'hffffffff);
    check_val(err, 1'b1, "unmapped write");
    apb(1'b0, 8'h08, 32'h0);
    check_val(err, 1'b1, "unmapped read error");
    check_val(rd, 32'h0, "unmapped read data");
    apb(1'b1, OFS_STATUS, 32'hffffffff);
    check_val(err, 1'b0, "status write");
    apb(1'b0, OFS_CONTROL, 32'h0);
    check_val(rd, 32'h00000060, "control kept");
  endtask

  task automatic t_ext();
    int c;
    do_reset(MODE_EXT_CLOCK, 1'b0);
    wait_cycles(4);
    check_val(cpu_hold, 1'b0, "no start-up delay");
    apb(1'b1, OFS_CONTROL, 32'h00000050);
    count_ticks(200, c);
    check_range(c, 44, 51, "pin ticks");
    pin_run <= 1'b0;
    wait_cycles(10);
    count_ticks(200, c);
    check_range(c, 0, 0, "ticks while stopped");
    apb(1'b0, OFS_CONTROL, 32'h0);
    check_val(cpu_hold, 1'b0, "hold kept");
    check_val(rd, 32'h00000050, "state kept");
    pin_run <= 1'b1;
    count_ticks(200, c);
    check_range(c, 44, 51, "ticks resumed");
    apb(1'b1, OFS_CONTROL, 32'h00000071);
    // A pin tick launched before the select lands may still arrive
    wait_cycles(2);
    count_ticks(8, c);
    check_range(c, 0, 0, "settle on switch");
    check_val(hf_en, 1'b1, "hf enable");
    hf_ready <= 1'b1;
    pin_run <= 1'b0;
    wait_cycles(60);
    apb(1'b0, OFS_STATUS, 32'h0);
    check_val(rd[STAT_HF_STABLE_BIT], 1'b1, "hf stable");
    count_ticks(800, c);
    check_range(c, 92, 101, "hf full rate");
    apb(1'b1, OFS_CONTROL, 32'h00000061);
    wait_cycles(60);
    count_ticks(800, c);
    check_range(c, 45, 51, "hf half rate");
    apb(1'b1, OFS_CONTROL, 32'h00000001);
    wait_cycles(10);
    check_val(hf_en, 1'b0, "hf off at low select");
    apb(1'b1, OFS_CONTROL, 32'h00000070);
    pin_run <= 1'b1;
    wait_cycles(60);
    check_val(hf_en, 1'b0, "hf off at external");
    count_ticks(800, c);
    check_range(c, 190, 201, "back to pin");
  endtask

  task automatic t_crystal();
    do_reset(MODE_HIGH_GAIN_XTAL, 1'b0);
    hold_count();
    wait_cycles(100);
    @(posedge ref_clk);
    wake <= 1'b1;
    pin_edges = 0;
    @(posedge ref_clk);
    wake <= 1'b0;
    wait_cycles(3);
    check_val(cpu_hold, 1'b1, "wake restart");
    hold_count();
    do_reset(MODE_MEDIUM_XTAL, 1'b1);
    wait_cycles(2000);
    check_val(cpu_hold, 1'b1, "count before power-up timer");
    @(posedge ref_clk);
    put_expired <= 1'b1;
    pin_edges = 0;
    @(posedge ref_clk);
    put_expired <= 1'b0;
    hold_count();
  endtask

  task automatic t_two_speed();
    int i, c;
    two_speed <= 1'b1;
    do_reset(MODE_LOW_POWER_XTAL, 1'b0);
    wait_cycles(100);
    check_val(hf_en, 1'b1, "two-speed hf enable");
    check_val(cpu_hold, 1'b0, "two-speed no hold");
    apb(1'b0, OFS_STATUS, 32'h0);
    check_val(rd, 32'h00000080, "two-speed on internal");
    count_ticks(800, c);
    check_range(c, 45, 51, "two-speed internal rate");
    for (i = 0; i < 8000 && pin_edges < 1100; i++) @(posedge ref_clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    check_val(rd, 32'h00000086, "two-speed handover");
    two_speed <= 1'b0;
  endtask

  task automatic t_modes();
    logic [4:0] exp;
    int i, t0;
    for (i = 0; i < 8; i++) begin
      case (osc_mode_e'(i))
        MODE_LOW_POWER_XTAL: exp = {3'b000, GAIN_LOW};
        MODE_MEDIUM_XTAL: exp = {3'b000, GAIN_MEDIUM};
        MODE_HIGH_GAIN_XTAL: exp = {3'b000, GAIN_HIGH};
        MODE_EXT_CLOCK: exp = {3'b010, GAIN_OFF};
        MODE_INT_OSC_IO: exp = {3'b110, GAIN_OFF};
        MODE_INT_OSC_CLOCK_OUT_FUNCTION: exp = {3'b101, GAIN_OFF};
        MODE_RC_IO: exp = {3'b010, GAIN_OFF};
        default: exp = {3'b001, GAIN_OFF};
      endcase
      do_reset(osc_mode_e'(i), 1'b0);
      wait_cycles(20);
      check_val(amp_gain, exp[1:0], "gain");
      if (i >= 3) check_val({osc_in_gpio, osc_out_gpio, osc_out_oe}, exp[4:2], "pins");
    end
    wait_rise();
    t0 = ticks;
    wait_rise();
    check_val(ticks - t0, 32'h4, "clock out period");
  endtask

  initial begin
    t_regs();
    t_ext();
    t_crystal();
    t_two_speed();
    t_modes();
    give_verdict();
  end
endmodule
